//--- pkg/offdelay_pulse_upcount_pkg.sv
// constants, types and register map of the off-delay, pulse and up-counter blocks
// assumes one 50 MHz system clock, synchronous reset, software access over APB
//
// Summary of operation
// [RL1] the off-delay output stays true while its trigger is true and timing starts when the trigger falls
// [RL2] when off-delay elapsed time reaches the preset, its output goes false and timing stops
// [RL3] a trigger returning true before the preset is reached clears elapsed time and leaves the output true
// [RL4] preset and elapsed times span zero up to the largest unsigned 64-bit nanosecond count
// [RL5] a rising pulse trigger drives the pulse output true and starts its elapsed time
// [RL6] when pulse elapsed time equals the preset, the pulse output goes false and timing stops
// [RL7] a pulse trigger that falls early lets timing run on to the preset, then clears time and output
// [RL8] after a completed pulse, a falling trigger clears the pulse elapsed time to zero
// [RL9] each rising count-up edge adds one to the count value
// [RL10] the counter output is true whenever the count value equals the preset count
// [RL11] once the count value has reached the preset count, further count-up edges are ignored
// [RL12] a true counter reset clears the count value to zero and the counter output to false
// [RL13] while counter reset is true, count-up edges do not count
// [RL14] a rising off-delay trigger clears its elapsed time and sets its output true again
// [RL15] preset count and count value are 32-bit unsigned numbers
// [RL16] elapsed time advances by a fixed number of nanoseconds every clock while a timer measures
package offdelay_pulse_upcount_pkg;

  localparam int          CLK_FREQ_MHZ  = 50;
  localparam int          CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
  localparam logic [63:0] NS_PER_CLK    = 64'(CLK_PERIOD_NS);
  // longest time: every bit of the 64-bit nanosecond count set
  localparam logic [63:0] TIME_MAX      = 64'hFFFF_FFFF_FFFF_FFFF;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS          = 8'h00;
  localparam logic [7:0] STATUS_OFS        = 8'h04;
  localparam logic [7:0] OFF_PT_LO_OFS     = 8'h08;
  localparam logic [7:0] OFF_PT_HI_OFS     = 8'h0C;
  localparam logic [7:0] OFF_ET_LO_OFS     = 8'h10;
  localparam logic [7:0] OFF_ET_HI_OFS     = 8'h14;
  localparam logic [7:0] PULSE_PT_LO_OFS   = 8'h18;
  localparam logic [7:0] PULSE_PT_HI_OFS   = 8'h1C;
  localparam logic [7:0] PULSE_ET_LO_OFS   = 8'h20;
  localparam logic [7:0] PULSE_ET_HI_OFS   = 8'h24;
  localparam logic [7:0] PRESET_COUNT_OFS  = 8'h28;
  localparam logic [7:0] COUNT_VALUE_OFS   = 8'h2C;

  // control bit positions
  localparam int CTRL_OFF_TRIG_BIT   = 0;
  localparam int CTRL_PULSE_TRIG_BIT = 1;
  localparam int CTRL_COUNT_UP_BIT   = 2;
  localparam int CTRL_CNT_RESET_BIT  = 3;
  localparam int CTRL_W              = 4;

  // status bit positions
  localparam int STAT_OFF_Q_BIT      = 0;
  localparam int STAT_PULSE_Q_BIT    = 1;
  localparam int STAT_COUNT_Q_BIT    = 2;
  localparam int STAT_PULSE_ST_LSB   = 4;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST         = 4'h0;
  localparam logic [63:0]       PT_RST           = 64'h0000_0000_0000_0000;
  localparam logic [31:0]       PRESET_COUNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_RUN,
    PULSE_DONE
  } pulse_state_e;

  typedef struct packed {
    logic        q;
    logic [63:0] et;
  } timer_s;

endpackage

//--- logic/offdelay_pulse_upcount.sv
// off-delay timer, pulse timer and 32-bit up counter behind an APB slave
// assumes a zero-wait APB master on SYS_CLK; triggers are written by software
module offdelay_pulse_upcount (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // block outputs
  output logic             OFF_DELAY_Q,
  output logic             PULSE_Q,
  output logic             COUNT_Q
);

  logic [offdelay_pulse_upcount_pkg::CTRL_W-1:0] ctrl_reg;
  logic [63:0]                                   off_pt_reg;
  logic [63:0]                                   pulse_pt_reg;
  logic [31:0]                                   preset_count_reg;
  logic [31:0]                                   count_value_reg;
  logic                                          count_q_reg;
  logic [31:0]                                   et_hi_snap_reg;
  logic [31:0]                                   prdata_reg;
  logic                                          off_trig_prev_reg;
  logic                                          pulse_trig_prev_reg;
  logic                                          count_up_prev_reg;
  offdelay_pulse_upcount_pkg::timer_s            off_reg;
  offdelay_pulse_upcount_pkg::timer_s            pulse_reg;
  offdelay_pulse_upcount_pkg::pulse_state_e      pulse_state_reg;

  logic        apb_setup;
  logic        apb_write;
  logic        addr_hit;
  logic [31:0] rd_data;
  logic        off_trig;
  logic        pulse_trig;
  logic        count_up_edge;
  logic        cnt_reset;
  logic        cu_rise;
  logic [63:0] off_pt_eff;
  logic [63:0] pulse_pt_eff;
  logic [63:0] off_et_next;
  logic [63:0] pulse_et_next;

  // decoded strobes and compares
  logic        rd_setup;
  logic        wr_ctrl;
  logic        wr_off_pt_lo;
  logic        wr_off_pt_hi;
  logic        wr_pulse_pt_lo;
  logic        wr_pulse_pt_hi;
  logic        wr_preset_count;
  logic        pulse_rise;
  logic        off_done;
  logic        pulse_done;
  logic        count_below;
  logic        count_at_preset;

  // single bound on a preset; the whole 64-bit range is legal, so no preset is cut
  function automatic logic [63:0] clamp_time(input logic [63:0] t);
    clamp_time = (t > offdelay_pulse_upcount_pkg::TIME_MAX) ? offdelay_pulse_upcount_pkg::TIME_MAX : t; // [RL4]
  endfunction

  // step toward the preset without overshooting it, so equality is always hit
  function automatic logic [63:0] step_time(input logic [63:0] et, input logic [63:0] pt);
    logic [64:0] sum;
    sum = {1'b0, et} + {1'b0, offdelay_pulse_upcount_pkg::NS_PER_CLK}; // [RL16]
    step_time = (sum >= {1'b0, pt}) ? pt : sum[63:0]; // [RL4]
  endfunction

  assign apb_setup     = PSEL & ~PENABLE;
  assign apb_write     = PSEL & PENABLE & PWRITE;
  assign off_trig      = ctrl_reg[offdelay_pulse_upcount_pkg::CTRL_OFF_TRIG_BIT];
  assign pulse_trig    = ctrl_reg[offdelay_pulse_upcount_pkg::CTRL_PULSE_TRIG_BIT];
  assign count_up_edge = ctrl_reg[offdelay_pulse_upcount_pkg::CTRL_COUNT_UP_BIT];
  assign cnt_reset     = ctrl_reg[offdelay_pulse_upcount_pkg::CTRL_CNT_RESET_BIT];
  assign cu_rise       = count_up_edge & ~count_up_prev_reg;
  assign off_pt_eff    = clamp_time(off_pt_reg);
  assign pulse_pt_eff  = clamp_time(pulse_pt_reg);
  assign off_et_next   = step_time(off_reg.et, off_pt_eff);
  assign pulse_et_next = step_time(pulse_reg.et, pulse_pt_eff);
  assign rd_setup      = apb_setup & ~PWRITE;
  assign pulse_rise    = pulse_trig & ~pulse_trig_prev_reg;

  // time never steps past the preset, but a lowered preset can sit below it, so done means at or above
  assign off_done      = off_reg.et >= off_pt_eff;
  assign pulse_done    = pulse_reg.et >= pulse_pt_eff;

  // less-than, not not-equal: a preset lowered below the count stops it at once
  assign count_below     = count_value_reg < preset_count_reg;
  assign count_at_preset = count_value_reg == preset_count_reg;

  // zero-wait slave; error only on an unmapped address
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;
  assign PRDATA  = prdata_reg;

  assign OFF_DELAY_Q = off_reg.q;
  assign PULSE_Q     = pulse_reg.q;
  assign COUNT_Q     = count_q_reg;

  // read decode
  always_comb begin
    rd_data  = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (PADDR)
      offdelay_pulse_upcount_pkg::CTRL_OFS: begin
        rd_data = {28'h000_0000, ctrl_reg};
      end
      offdelay_pulse_upcount_pkg::STATUS_OFS: begin
        rd_data[offdelay_pulse_upcount_pkg::STAT_OFF_Q_BIT]   = off_reg.q;
        rd_data[offdelay_pulse_upcount_pkg::STAT_PULSE_Q_BIT] = pulse_reg.q;
        rd_data[offdelay_pulse_upcount_pkg::STAT_COUNT_Q_BIT] = count_q_reg;
        rd_data[offdelay_pulse_upcount_pkg::STAT_PULSE_ST_LSB +: 2] = pulse_state_reg;
      end
      offdelay_pulse_upcount_pkg::OFF_PT_LO_OFS: begin
        rd_data = off_pt_reg[31:0];
      end
      offdelay_pulse_upcount_pkg::OFF_PT_HI_OFS: begin
        rd_data = off_pt_reg[63:32];
      end
      offdelay_pulse_upcount_pkg::OFF_ET_LO_OFS: begin
        rd_data = off_reg.et[31:0];
      end
      offdelay_pulse_upcount_pkg::OFF_ET_HI_OFS: begin
        rd_data = et_hi_snap_reg;
      end
      offdelay_pulse_upcount_pkg::PULSE_PT_LO_OFS: begin
        rd_data = pulse_pt_reg[31:0];
      end
      offdelay_pulse_upcount_pkg::PULSE_PT_HI_OFS: begin
        rd_data = pulse_pt_reg[63:32];
      end
      offdelay_pulse_upcount_pkg::PULSE_ET_LO_OFS: begin
        rd_data = pulse_reg.et[31:0];
      end
      offdelay_pulse_upcount_pkg::PULSE_ET_HI_OFS: begin
        rd_data = et_hi_snap_reg;
      end
      offdelay_pulse_upcount_pkg::PRESET_COUNT_OFS: begin
        rd_data = preset_count_reg;
      end
      offdelay_pulse_upcount_pkg::COUNT_VALUE_OFS: begin
        rd_data = count_value_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // one strobe per writable word; read-only and unmapped words get none, so writes there drop
  always_comb begin
    wr_ctrl         = 1'b0;
    wr_off_pt_lo    = 1'b0;
    wr_off_pt_hi    = 1'b0;
    wr_pulse_pt_lo  = 1'b0;
    wr_pulse_pt_hi  = 1'b0;
    wr_preset_count = 1'b0;
    if (apb_write) begin
      unique case (PADDR)
        offdelay_pulse_upcount_pkg::CTRL_OFS: begin
          wr_ctrl = 1'b1;
        end
        offdelay_pulse_upcount_pkg::OFF_PT_LO_OFS: begin
          wr_off_pt_lo = 1'b1;
        end
        offdelay_pulse_upcount_pkg::OFF_PT_HI_OFS: begin
          wr_off_pt_hi = 1'b1;
        end
        offdelay_pulse_upcount_pkg::PULSE_PT_LO_OFS: begin
          wr_pulse_pt_lo = 1'b1;
        end
        offdelay_pulse_upcount_pkg::PULSE_PT_HI_OFS: begin
          wr_pulse_pt_hi = 1'b1;
        end
        offdelay_pulse_upcount_pkg::PRESET_COUNT_OFS: begin
          wr_preset_count = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // read data is captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_data;
    end
  end

  // low-word read freezes the high word, so a 64-bit time reads coherently
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      et_hi_snap_reg <= 32'h0000_0000;
    end else if (rd_setup && PADDR == offdelay_pulse_upcount_pkg::OFF_ET_LO_OFS) begin
      et_hi_snap_reg <= off_reg.et[63:32];
    end else if (rd_setup && PADDR == offdelay_pulse_upcount_pkg::PULSE_ET_LO_OFS) begin
      et_hi_snap_reg <= pulse_reg.et[63:32];
    end
  end

  // control register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= offdelay_pulse_upcount_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= PWDATA[offdelay_pulse_upcount_pkg::CTRL_W-1:0];
    end
  end

  // preset times; halves are written separately, so a running timer may see a mixed value
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      off_pt_reg   <= offdelay_pulse_upcount_pkg::PT_RST;
      pulse_pt_reg <= offdelay_pulse_upcount_pkg::PT_RST;
    end else begin
      if (wr_off_pt_lo) begin
        off_pt_reg[31:0] <= PWDATA;
      end
      if (wr_off_pt_hi) begin
        off_pt_reg[63:32] <= PWDATA;
      end
      if (wr_pulse_pt_lo) begin
        pulse_pt_reg[31:0] <= PWDATA;
      end
      if (wr_pulse_pt_hi) begin
        pulse_pt_reg[63:32] <= PWDATA;
      end
    end
  end

  // preset count
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      preset_count_reg <= offdelay_pulse_upcount_pkg::PRESET_COUNT_RST; // [RL15]
    end else if (wr_preset_count) begin
      preset_count_reg <= PWDATA;
    end
  end

  // trigger history; the pulse and count-up copies feed edge detection, the off-delay copy feeds nothing
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      off_trig_prev_reg   <= 1'b0;
      pulse_trig_prev_reg <= 1'b0;
      count_up_prev_reg   <= 1'b0;
    end else begin
      off_trig_prev_reg   <= off_trig;
      pulse_trig_prev_reg <= pulse_trig;
      count_up_prev_reg   <= count_up_edge;
    end
  end

  // off-delay timer
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      off_reg.q  <= 1'b0;
      off_reg.et <= 64'h0000_0000_0000_0000;
    end else if (off_trig) begin
      off_reg.q  <= 1'b1; // [RL1] [RL14]
      off_reg.et <= 64'h0000_0000_0000_0000; // [RL3] [RL14]
    end else if (off_reg.q) begin
      if (off_done) begin
        off_reg.q <= 1'b0; // [RL2]
      end else begin
        off_reg.et <= off_et_next; // [RL1] [RL16]
      end
    end
  end

  // pulse timer; a trigger still high after the pulse ends does not start another
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_IDLE;
      pulse_reg.q     <= 1'b0;
      pulse_reg.et    <= 64'h0000_0000_0000_0000;
    end else begin
      unique case (pulse_state_reg)
        offdelay_pulse_upcount_pkg::PULSE_IDLE: begin
          if (pulse_rise) begin
            pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_RUN;
            pulse_reg.q     <= 1'b1; // [RL5]
            pulse_reg.et    <= 64'h0000_0000_0000_0000; // [RL5]
          end
        end
        offdelay_pulse_upcount_pkg::PULSE_RUN: begin
          if (pulse_done) begin
            pulse_reg.q <= 1'b0; // [RL6]
            if (pulse_trig) begin
              pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_DONE; // [RL6]
            end else begin
              pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_IDLE;
              pulse_reg.et    <= 64'h0000_0000_0000_0000; // [RL7]
            end
          end else begin
            pulse_reg.et <= pulse_et_next; // [RL5] [RL7] [RL16]
          end
        end
        offdelay_pulse_upcount_pkg::PULSE_DONE: begin
          if (!pulse_trig) begin
            pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_IDLE;
            pulse_reg.et    <= 64'h0000_0000_0000_0000; // [RL8]
          end
        end
        default: begin
          pulse_state_reg <= offdelay_pulse_upcount_pkg::PULSE_IDLE;
          pulse_reg.q     <= 1'b0;
        end
      endcase
    end
  end

  // up counter; counting stops above the preset too, so a lowered preset never wraps
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count_value_reg <= 32'h0000_0000;
    end else if (cnt_reset) begin
      count_value_reg <= 32'h0000_0000; // [RL12] [RL13]
    end else if (cu_rise && count_below) begin
      count_value_reg <= count_value_reg + 32'h0000_0001; // [RL9] [RL11] [RL15]
    end
  end

  // counter output follows the compare one clock later
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count_q_reg <= 1'b0;
    end else begin
      count_q_reg <= !cnt_reset && count_at_preset; // [RL10] [RL12]
    end
  end

endmodule

//--- sim/offdelay_pulse_upcount_asserts.sv
// port checker for the off-delay, pulse and up-counter block
// assumes zero-wait apb and triggers written only over the bus
module offdelay_pulse_upcount_asserts (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // outputs
  input wire logic        OFF_DELAY_Q,
  input wire logic        PULSE_Q,
  input wire logic        COUNT_Q
);
  logic       acc;
  logic       ctl_wr;
  logic [3:0] ctl_reg;
  logic [2:0] hist_reg;
  assign acc    = PSEL && PENABLE;
  assign ctl_wr = acc && PWRITE && PADDR == offdelay_pulse_upcount_pkg::CTRL_OFS;
  // shadow of the triggers, which the block keeps inside
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctl_reg <= 4'h0;
    end else if (ctl_wr) begin
      ctl_reg <= PWDATA[3:0];
    end
  end
  // a write or reset may move the counter output up to three edges on
  always_ff @(posedge SYS_CLK) begin
    hist_reg <= {hist_reg[1:0], RST || (acc && PWRITE)};
  end
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  ready_high_a: assert property (PREADY) else $error("pready low");
  err_phase_a: assert property (!acc |-> !PSLVERR) else $error("pslverr outside access");
  err_map_a: assert property (acc && (PADDR > 8'h2C || PADDR[1:0] != 2'h0) |-> PSLVERR)
    else $error("no error on unmapped address");
  off_hold_a: assert property (ctl_reg[0] && $past(ctl_reg[0]) |-> OFF_DELAY_Q)
    else $error("off-delay output low while triggered");
  off_rise_a: assert property ($rose(OFF_DELAY_Q) |-> $past(ctl_reg[0]))
    else $error("off-delay output rose untriggered");
  pulse_start_a: assert property ($rose(PULSE_Q) |-> $past(ctl_reg[1]) && !$past(ctl_reg[1], 2))
    else $error("pulse output rose without trigger edge");
  cnt_clear_a: assert property (ctl_wr && PWDATA[3] |-> ##2 !COUNT_Q)
    else $error("counter output not cleared");
  cnt_hold_a: assert property (ctl_reg[3] && $past(ctl_reg[3]) |-> !COUNT_Q)
    else $error("counter output high during reset");
  cnt_steady_a: assert property ($changed(COUNT_Q) |-> |hist_reg)
    else $error("counter output moved without cause");
endmodule

bind offdelay_pulse_upcount offdelay_pulse_upcount_asserts i_chk (.SYS_CLK, .RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .OFF_DELAY_Q, .PULSE_Q, .COUNT_Q);

//--- sim/offdelay_pulse_upcount_tb.sv
// self-checking bench for the off-delay, pulse and up-counter block
// assumes a zero-wait apb slave on one 50 MHz clock
module offdelay_pulse_upcount_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        off_q;
  logic        pulse_q;
  logic        count_q;
  logic [31:0] rd;
  logic        err;
  logic [31:0] pt;
  logic [31:0] pv;
  logic [7:0]  bad [3] = '{8'h30, 8'h2E, 8'hFC};
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;

  offdelay_pulse_upcount i_dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .OFF_DELAY_Q(off_q), .PULSE_Q(pulse_q), .COUNT_Q(count_q));

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // edges from trigger fall to output fall: steps up to the preset, then one more
  function automatic int off_edges(input logic [31:0] p);
    return int'(64'(p) / offdelay_pulse_upcount_pkg::NS_PER_CLK) + 1;
  endfunction

  // count after i rising count-up edges, held once it meets the preset
  function automatic logic [31:0] exp_count(input int i, input logic [31:0] p);
    return (32'(i) < p) ? 32'(i) : p;
  endfunction

  task automatic pause(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  initial begin
    forever #10 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h271F));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h0);
    xfer(1'b0, offdelay_pulse_upcount_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h4);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, bad[i], 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
    end
    xfer(1'b1, offdelay_pulse_upcount_pkg::COUNT_VALUE_OFS, $urandom);
    xfer(1'b0, offdelay_pulse_upcount_pkg::COUNT_VALUE_OFS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, offdelay_pulse_upcount_pkg::PRESET_COUNT_OFS, 32'hFFFF_FFFF);
    xfer(1'b0, offdelay_pulse_upcount_pkg::PRESET_COUNT_OFS, 32'h0);
    chk(rd, 32'hFFFF_FFFF);
    xfer(1'b1, offdelay_pulse_upcount_pkg::OFF_PT_HI_OFS, 32'hFFFF_FFFF);
    xfer(1'b0, offdelay_pulse_upcount_pkg::OFF_PT_HI_OFS, 32'h0);
    chk(rd, 32'hFFFF_FFFF);
    $display("test registers done");
    // off-delay: preset a whole number of clock steps
    pt = 32'd20 * (32'd50 + $urandom % 50);
    xfer(1'b1, offdelay_pulse_upcount_pkg::OFF_PT_LO_OFS, pt);
    xfer(1'b1, offdelay_pulse_upcount_pkg::OFF_PT_HI_OFS, 32'h0);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h1);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
    pause(10);
    chk(32'(off_q), 32'h1);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h1);
    xfer(1'b0, offdelay_pulse_upcount_pkg::OFF_ET_LO_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(off_q), 32'h1);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (off_q !== 1'b0 && n < 400);
    chk(32'(n), 32'(off_edges(pt)));
    pause(5);
    xfer(1'b0, offdelay_pulse_upcount_pkg::OFF_ET_LO_OFS, 32'h0);
    chk(rd, pt);
    xfer(1'b0, offdelay_pulse_upcount_pkg::OFF_ET_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h1);
    xfer(1'b0, offdelay_pulse_upcount_pkg::OFF_ET_LO_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(off_q), 32'h1);
    $display("test off delay done");
    pt = 32'd20 * (32'd20 + $urandom % 20);
    xfer(1'b1, offdelay_pulse_upcount_pkg::PULSE_PT_LO_OFS, pt);
    xfer(1'b1, offdelay_pulse_upcount_pkg::PULSE_PT_HI_OFS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      // trigger low first, so every pass sees a fresh rising edge
      xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
      xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h2);
      if (k == 1) begin
        xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
      end
      pause(2);
      chk(32'(pulse_q), 32'h1);
      pause(pt / 20 + 4);
      chk(32'(pulse_q), 32'h0);
      xfer(1'b0, offdelay_pulse_upcount_pkg::PULSE_ET_LO_OFS, 32'h0);
      chk(rd, (k == 0) ? pt : 32'h0);
    end
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h2);
    pause(pt / 20 + 4);
    xfer(1'b0, offdelay_pulse_upcount_pkg::PULSE_ET_LO_OFS, 32'h0);
    chk(rd, pt);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
    xfer(1'b0, offdelay_pulse_upcount_pkg::PULSE_ET_LO_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test pulse done");
    pv = 32'd2 + $urandom % 6;
    xfer(1'b1, offdelay_pulse_upcount_pkg::PRESET_COUNT_OFS, pv);
    for (int i = 1; i < pv + 3; i++) begin
      xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h4);
      xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
      xfer(1'b0, offdelay_pulse_upcount_pkg::COUNT_VALUE_OFS, 32'h0);
      chk(rd, exp_count(i, pv));
      chk(32'(count_q), 32'(i >= pv));
    end
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h8);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'hC);
    xfer(1'b0, offdelay_pulse_upcount_pkg::COUNT_VALUE_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(count_q), 32'h0);
    xfer(1'b1, offdelay_pulse_upcount_pkg::CTRL_OFS, 32'h0);
    $display("test counter done");
    final_report();
  end
endmodule
